// [logic/tecc_top.sv]
// Touch event, blocking and calibration request control for three sense inputs.
// Assumes touch, noise and calibration-engine inputs come from logic on CLK_SYS,
// and the register port is driven by the serial protocol engine on the same clock.
`timescale 1ns/1ps
module tecc_top
	import tecc_pkg::*;
#(
	parameter int STEP_COUNT = STEP_CYCLES
) (
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	input wire logic [2:0] TOUCH_RAW,
	input wire logic [2:0] NOISE_FLAG,
	input wire logic [2:0] ACTIVE_CH_ENABLE,
	input wire logic [2:0] STANDBY_CH_ENABLE,
	input wire logic STANDBY_MODE,
	input wire logic DEEP_SLEEP,
	input wire logic RELEASE_INTERRUPT_DISABLE,
	input wire logic [3:0] REPEAT_INTERVAL,
	input wire logic [3:0] HOLD_THRESHOLD,
	input wire logic STATUS_CLEAR,
	output logic CAL_START,
	output logic [1:0] CAL_SEL,
	input wire logic CAL_DONE,
	input wire logic [9:0] CAL_RESULT,
	output logic [29:0] INPUT_CALIBRATION_VALUE,
	output logic ANALOG_CALIBRATION_FAILURE_FLAG,
	output logic TOUCH_LIMIT_EXCEEDED_FLAG,
	output logic [2:0] TOUCH_FLAG,
	output logic ALERT_N
);

	initial begin
		if (STEP_COUNT < 1 || STEP_COUNT >= (1 << 21)) begin
			$error("STEP_COUNT out of range");
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [20:0] step_cnt_ff, nxt_step_cnt;
	logic step_tick_ff, nxt_step_tick;
	logic [2:0] cal_req_ff, nxt_cal_req;
	logic [2:0] cal_tried_ff, nxt_cal_tried;
	logic [2:0] alert_en_ff, nxt_alert_en;
	logic [2:0] repeat_en_ff, nxt_repeat_en;
	logic block_en_ff, nxt_block_en;
	logic [1:0] limit_ff, nxt_limit;
	logic [7:0] rdata_ff, nxt_rdata;
	logic [2:0] ch_on_ff, nxt_ch_on;
	tecc_cal_state_t cal_state_ff, nxt_cal_state;
	logic [1:0] cal_sel_ff, nxt_cal_sel;
	logic cal_start_ff, nxt_cal_start;
	logic [9:0] cal_val_ff [3];
	logic [9:0] nxt_cal_val [3];
	logic cal_fail_ff, nxt_cal_fail;
	logic [2:0] valid_ff, nxt_valid;
	logic exceeded_ff, nxt_exceeded;
	logic [2:0] chan_event;
	logic alert_pend_ff, nxt_alert_pend;
	logic alert_n_ff, nxt_alert_n;
	logic [2:0] ch_on_now;
	logic [2:0] new_enable;
	logic wr_cal;
	logic cal_ok;

	////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [1:0] count3(input logic [2:0] v);
		count3 = 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
	endfunction : count3

	// Limit field to number of allowed touches
	function automatic logic [1:0] limit_of(input logic [1:0] code);
		logic [1:0] n;
		n = 2'd3;
		if (code == 2'b00) begin
			n = 2'd1;
		end else if (code == 2'b01) begin
			n = 2'd2;
		end
		limit_of = n;
	endfunction : limit_of

	// Keep the given inputs, then add candidates in input order up to the limit
	function automatic logic [2:0] pick(input logic [2:0] keep, input logic [2:0] cand,
			input logic [1:0] lim);
		logic [2:0] sel;
		logic [1:0] cnt;
		sel = keep;
		cnt = count3(keep);
		for (int i = 0; i < 3; i++) begin
			if (cand[i] && !sel[i] && cnt < lim) begin
				sel[i] = 1'b1;
				cnt = cnt + 2'd1;
			end
		end
		pick = sel;
	endfunction : pick

	////////////////////////////////////////////////////////////////////////////
	// 35 ms step divider
	always_comb begin
		nxt_step_tick = 1'b0;
		nxt_step_cnt = step_cnt_ff + 21'd1;
		if (step_cnt_ff == 21'(STEP_COUNT - 1)) begin
			nxt_step_cnt = 21'h0;
			nxt_step_tick = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			step_cnt_ff <= 21'h0;
			step_tick_ff <= 1'b0;
		end else begin
			step_cnt_ff <= nxt_step_cnt;
			step_tick_ff <= nxt_step_tick;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Enabled-input tracking for automatic calibration requests
	always_comb begin
		if (DEEP_SLEEP) begin
			ch_on_now = 3'h0;
		end else if (STANDBY_MODE) begin
			ch_on_now = STANDBY_CH_ENABLE;
		end else begin
			ch_on_now = ACTIVE_CH_ENABLE;
		end
		nxt_ch_on = ch_on_now;
		new_enable = ch_on_now & ~ch_on_ff;
	end

	////////////////////////////////////////////////////////////////////////////
	// Register file, calibration requests and sequencer
	always_comb begin
		wr_cal = REG_WR && (REG_ADDR == ADDR_CAL_TRIGGER);
		cal_ok = (NOISE_FLAG[cal_sel_ff] == 1'b0) && (CAL_RESULT != CAL_VALUE_MIN)
			&& (CAL_RESULT != CAL_VALUE_MAX);
		nxt_cal_req = cal_req_ff;
		nxt_cal_tried = cal_tried_ff;
		nxt_cal_state = cal_state_ff;
		nxt_cal_sel = cal_sel_ff;
		nxt_cal_start = 1'b0;
		nxt_cal_fail = cal_fail_ff;
		for (int i = 0; i < 3; i++) begin
			nxt_cal_val[i] = cal_val_ff[i];
		end
		if (STATUS_CLEAR) begin
			nxt_cal_fail = 1'b0;
		end
		unique case (cal_state_ff)
			CAL_IDLE: begin
				for (int i = 2; i >= 0; i--) begin
					if (cal_req_ff[i] && !cal_tried_ff[i]) begin
						nxt_cal_sel = 2'(i);
					end
				end
				if ((cal_req_ff & ~cal_tried_ff) != 3'h0) begin
					nxt_cal_start = 1'b1;
					nxt_cal_tried[nxt_cal_sel] = 1'b1;
					nxt_cal_state = CAL_RUN;
				end
			end
			CAL_RUN: begin
				if (CAL_DONE) begin
					nxt_cal_val[cal_sel_ff] = CAL_RESULT;
					nxt_cal_state = CAL_IDLE;
					if (cal_ok) begin
						nxt_cal_req[cal_sel_ff] = 1'b0;
					end else begin
						nxt_cal_fail = 1'b1;
					end
				end
			end
		endcase
		if (wr_cal) begin
			// Zero cancels a request not yet started, one forces a new run
			nxt_cal_req = REG_WDATA[INPUT_MSB:0];
			nxt_cal_tried = nxt_cal_tried & ~REG_WDATA[INPUT_MSB:0];
		end
		nxt_cal_req = nxt_cal_req | new_enable;
		nxt_cal_tried = nxt_cal_tried & ~new_enable;
	end

	always_comb begin
		nxt_alert_en = alert_en_ff;
		nxt_repeat_en = repeat_en_ff;
		nxt_block_en = block_en_ff;
		nxt_limit = limit_ff;
		nxt_rdata = rdata_ff;
		if (REG_WR) begin
			unique case (REG_ADDR)
				ADDR_ALERT_ENABLE: nxt_alert_en = REG_WDATA[INPUT_MSB:0];
				ADDR_REPEAT_ENABLE: nxt_repeat_en = REG_WDATA[INPUT_MSB:0];
				ADDR_LIMIT_CONFIG: begin
					nxt_block_en = REG_WDATA[BLOCK_EN_BIT];
					nxt_limit = REG_WDATA[LIMIT_MSB:LIMIT_LSB];
				end
				default: begin
				end
			endcase
		end
		if (REG_RD) begin
			unique case (REG_ADDR)
				ADDR_CAL_TRIGGER: nxt_rdata = {5'h00, cal_req_ff};
				ADDR_ALERT_ENABLE: nxt_rdata = {5'h00, alert_en_ff};
				ADDR_REPEAT_ENABLE: nxt_rdata = {5'h00, repeat_en_ff};
				ADDR_LIMIT_CONFIG: nxt_rdata = {block_en_ff, 3'h0, limit_ff, 2'h0};
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			cal_req_ff <= RST_CAL_TRIGGER[INPUT_MSB:0];
			cal_tried_ff <= 3'h0;
			alert_en_ff <= RST_ALERT_ENABLE[INPUT_MSB:0];
			repeat_en_ff <= RST_REPEAT_ENABLE[INPUT_MSB:0];
			block_en_ff <= RST_LIMIT_CONFIG[BLOCK_EN_BIT];
			limit_ff <= RST_LIMIT_CONFIG[LIMIT_MSB:LIMIT_LSB];
			rdata_ff <= 8'h00;
			ch_on_ff <= 3'h0;
			cal_state_ff <= CAL_IDLE;
			cal_sel_ff <= 2'h0;
			cal_start_ff <= 1'b0;
			cal_fail_ff <= 1'b0;
			for (int i = 0; i < 3; i++) begin
				cal_val_ff[i] <= 10'h000;
			end
		end else begin
			cal_req_ff <= nxt_cal_req;
			cal_tried_ff <= nxt_cal_tried;
			alert_en_ff <= nxt_alert_en;
			repeat_en_ff <= nxt_repeat_en;
			block_en_ff <= nxt_block_en;
			limit_ff <= nxt_limit;
			rdata_ff <= nxt_rdata;
			ch_on_ff <= nxt_ch_on;
			cal_state_ff <= nxt_cal_state;
			cal_sel_ff <= nxt_cal_sel;
			cal_start_ff <= nxt_cal_start;
			cal_fail_ff <= nxt_cal_fail;
			for (int i = 0; i < 3; i++) begin
				cal_val_ff[i] <= nxt_cal_val[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Simultaneous touch blocking
	always_comb begin
		nxt_exceeded = 1'b0;
		if (!block_en_ff) begin
			nxt_valid = TOUCH_RAW;
		end else if ((valid_ff & ~TOUCH_RAW) != 3'h0) begin
			nxt_valid = pick(3'h0, TOUCH_RAW, limit_of(limit_ff));
		end else begin
			nxt_valid = pick(valid_ff, TOUCH_RAW, limit_of(limit_ff));
		end
		if (block_en_ff && count3(TOUCH_RAW) > limit_of(limit_ff)) begin
			nxt_exceeded = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			valid_ff <= 3'h0;
			exceeded_ff <= 1'b0;
		end else begin
			valid_ff <= nxt_valid;
			exceeded_ff <= nxt_exceeded;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-input touch, release and repeat events
	for (genvar g = 0; g < 3; g++) begin : g_chan
		logic prev_ff, nxt_prev;
		logic [4:0] hold_ff, nxt_hold;
		logic [4:0] rpt_ff, nxt_rpt;
		logic held;
		logic ev;

		always_comb begin
			nxt_prev = valid_ff[g];
			nxt_hold = hold_ff;
			nxt_rpt = rpt_ff;
			held = hold_ff > ({1'b0, HOLD_THRESHOLD} + 5'd1);
			ev = 1'b0;
			if (valid_ff[g] && !prev_ff) begin
				ev = 1'b1;
				nxt_hold = 5'h0;
				nxt_rpt = 5'h0;
			end else if (!valid_ff[g] && prev_ff) begin
				ev = !RELEASE_INTERRUPT_DISABLE;
				nxt_hold = 5'h0;
			end else if (valid_ff[g] && step_tick_ff) begin
				if (hold_ff != 5'h1F) begin
					nxt_hold = hold_ff + 5'd1;
				end
				nxt_rpt = (rpt_ff == 5'h1F) ? rpt_ff : rpt_ff + 5'd1;
				if (held && repeat_en_ff[g]
						&& (rpt_ff + 5'd1) > {1'b0, REPEAT_INTERVAL}) begin
					ev = 1'b1;
					nxt_rpt = 5'h0;
				end
			end
			chan_event[g] = ev && alert_en_ff[g];
		end

		always_ff @(posedge CLK_SYS) begin
			if (SYS_RST) begin
				prev_ff <= 1'b0;
				hold_ff <= 5'h0;
				rpt_ff <= 5'h0;
			end else begin
				prev_ff <= nxt_prev;
				hold_ff <= nxt_hold;
				rpt_ff <= nxt_rpt;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Alert latch, set wins over clear
	always_comb begin
		nxt_alert_pend = alert_pend_ff;
		if (STATUS_CLEAR) begin
			nxt_alert_pend = 1'b0;
		end
		if (chan_event != 3'h0) begin
			nxt_alert_pend = 1'b1;
		end
		nxt_alert_n = !nxt_alert_pend;
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			alert_pend_ff <= 1'b0;
			alert_n_ff <= 1'b1;
		end else begin
			alert_pend_ff <= nxt_alert_pend;
			alert_n_ff <= nxt_alert_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign REG_RDATA = rdata_ff;
	assign CAL_START = cal_start_ff;
	assign CAL_SEL = cal_sel_ff;
	assign INPUT_CALIBRATION_VALUE = {cal_val_ff[2], cal_val_ff[1], cal_val_ff[0]};
	assign ANALOG_CALIBRATION_FAILURE_FLAG = cal_fail_ff;
	assign TOUCH_LIMIT_EXCEEDED_FLAG = exceeded_ff;
	assign TOUCH_FLAG = valid_ff;
	assign ALERT_N = alert_n_ff;

endmodule : tecc_top

// [logic/tecc_pkg.sv]
// Constants for the touch event and calibration control block.
// Assumes a 40 MHz system clock and a register port fed by the serial protocol engine.
//
// Function
// - Writing one requests calibration of that input
// - Finished calibration updates the ten-bit value
// - Successful calibration clears the request bit itself
// - Newly enabled input sets its request bit
// - Uncleared request after calibration sets failure flag
// - Noise or limit value keeps request bit set
// - Writing zero cancels calibration not yet reached
// - Per-input enable gates alert for that input
// - Repeat off: one alert on touch, release
// - Repeat on, short touch: touch and release
// - Repeat on, held: alerts at repeat interval
// - Blocking disabled passes every simultaneous touch
// - Blocking flags up to limit, holds others
// - After release, reselect in input order
// - Too many touches sets exceeded flag
// - Limit field: 00 one, 01 two, else three
// - Longer than hold threshold means press-and-hold
// - Repeat interval in 35 ms steps
package tecc_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_CAL_TRIGGER = 8'h26;
	localparam logic [7:0] ADDR_ALERT_ENABLE = 8'h27;
	localparam logic [7:0] ADDR_REPEAT_ENABLE = 8'h28;
	localparam logic [7:0] ADDR_LIMIT_CONFIG = 8'h2A;
	// Reset values
	localparam logic [7:0] RST_CAL_TRIGGER = 8'h00;
	localparam logic [7:0] RST_ALERT_ENABLE = 8'h07;
	localparam logic [7:0] RST_REPEAT_ENABLE = 8'h07;
	localparam logic [7:0] RST_LIMIT_CONFIG = 8'h80;
	// Field positions
	localparam int BLOCK_EN_BIT = 7;
	localparam int LIMIT_LSB = 2;
	localparam int LIMIT_MSB = 3;
	localparam int INPUT_MSB = 2;
	// Calibration value range
	localparam logic [9:0] CAL_VALUE_MIN = 10'h000;
	localparam logic [9:0] CAL_VALUE_MAX = 10'h3FF;
	// Timing: one step of the hold and repeat settings
	localparam int CLK_PERIOD_NS = 25;
	localparam int STEP_TIME_NS = 35_000_000;
	localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
	// Calibration sequencer states
	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_RUN = 2'b01
	} tecc_cal_state_t;
endpackage : tecc_pkg

// [tb/tecc_cal_model.sv]
// Calibration engine stand-in: answers each start with done after a set delay.
// Assumes start comes from the block on the same clock; the bench sets delay and result.
`timescale 1ns/1ps
module tecc_cal_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [7:0] dly,
	input wire logic [9:0] res,
	output logic done,
	output logic [9:0] result
);
	int cnt;
	// Count the run down, pulse done; result is scrambled outside the done cycle
	always_ff @(posedge clk) begin
		done <= 1'b0;
		result <= ~result;
		if (rst) begin
			cnt <= 0;
			result <= 10'h155;
		end else if (start) begin
			cnt <= int'(dly);
		end else if (cnt == 1) begin
			done <= 1'b1;
			result <= res;
			cnt <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule : tecc_cal_model

// [tb/tecc_chk.sv]
// Port checks for the touch event and calibration control block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module tecc_chk (
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	input wire logic [2:0] TOUCH_RAW,
	input wire logic STATUS_CLEAR,
	input wire logic CAL_START,
	input wire logic [1:0] CAL_SEL,
	input wire logic CAL_DONE,
	input wire logic ANALOG_CALIBRATION_FAILURE_FLAG,
	input wire logic TOUCH_LIMIT_EXCEEDED_FLAG,
	input wire logic [2:0] TOUCH_FLAG,
	input wire logic ALERT_N
);
	logic run_ff;
	logic nxt_run;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	// Track an open calibration run
	always_comb nxt_run = CAL_START | (run_ff & ~CAL_DONE);
	always_ff @(posedge CLK_SYS) run_ff <= SYS_RST ? 1'b0 : nxt_run;
	a_alert_hold: assert property (!ALERT_N && !STATUS_CLEAR |=> !ALERT_N)
		else $error("alert released without clear");
	a_start_pulse: assert property (CAL_START |=> !CAL_START)
		else $error("start pulse too long");
	a_single_run: assert property (CAL_START |-> !run_ff)
		else $error("start during a run");
	a_sel_hold: assert property (!CAL_START |-> $stable(CAL_SEL))
		else $error("selection moved without start");
	a_flag_subset: assert property ((TOUCH_FLAG & ~$past(TOUCH_RAW)) == 3'h0)
		else $error("flag without touch");
	a_excess_cause: assert property (TOUCH_LIMIT_EXCEEDED_FLAG
		|-> $countones($past(TOUCH_RAW)) > 1)
		else $error("exceeded flag without touches");
	a_excess_block: assert property (TOUCH_LIMIT_EXCEEDED_FLAG
		|-> TOUCH_FLAG != $past(TOUCH_RAW))
		else $error("nothing blocked over limit");
	a_fail_sticky: assert property (ANALOG_CALIBRATION_FAILURE_FLAG && !STATUS_CLEAR
		|=> ANALOG_CALIBRATION_FAILURE_FLAG)
		else $error("failure flag dropped");
	a_fail_cause: assert property ($rose(ANALOG_CALIBRATION_FAILURE_FLAG) |-> $past(CAL_DONE))
		else $error("failure flag without done");
endmodule : tecc_chk
bind tecc_top tecc_chk i_tecc_chk (.CLK_SYS, .SYS_RST, .TOUCH_RAW, .STATUS_CLEAR, .CAL_START,
	.CAL_SEL, .CAL_DONE, .ANALOG_CALIBRATION_FAILURE_FLAG, .TOUCH_LIMIT_EXCEEDED_FLAG,
	.TOUCH_FLAG, .ALERT_N);

// [tb/tecc_top_tb_top.sv]
// Self-checking bench for the touch event and calibration control block.
// Assumes a shortened step count; the hold threshold code is held fixed.
`timescale 1ns/1ps
module tecc_top_tb_top;
	import tecc_pkg::*;
	localparam int STEP = 4;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [2:0] raw = 3'h0;
	logic [2:0] noise = 3'h0;
	logic [2:0] act_en = 3'h0;
	logic [2:0] stby_en = 3'h0;
	logic stby = 1'b0;
	logic sleep = 1'b0;
	logic [3:0] rpt_iv = 4'h0;
	logic rel_dis = 1'b0;
	logic clr = 1'b0;
	logic [7:0] dly = 8'h04;
	logic [9:0] res = 10'h123;
	logic [7:0] rdata;
	logic cal_start;
	logic [1:0] cal_sel;
	logic cal_done;
	logic [9:0] cal_result;
	logic [29:0] cal_val;
	logic fail;
	logic excess;
	logic [2:0] flag;
	logic alert_n;
	int err_total = 0;
	int tests_run = 0;
	int starts = 0;
	int cycles = 0;
	tecc_top #(.STEP_COUNT(STEP)) i_tecc_top (.CLK_SYS(clk), .SYS_RST(rst), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .TOUCH_RAW(raw),
		.NOISE_FLAG(noise), .ACTIVE_CH_ENABLE(act_en), .STANDBY_CH_ENABLE(stby_en),
		.STANDBY_MODE(stby), .DEEP_SLEEP(sleep), .RELEASE_INTERRUPT_DISABLE(rel_dis),
		.REPEAT_INTERVAL(rpt_iv), .HOLD_THRESHOLD(4'h1), .STATUS_CLEAR(clr),
		.CAL_START(cal_start), .CAL_SEL(cal_sel), .CAL_DONE(cal_done), .CAL_RESULT(cal_result),
		.INPUT_CALIBRATION_VALUE(cal_val), .ANALOG_CALIBRATION_FAILURE_FLAG(fail),
		.TOUCH_LIMIT_EXCEEDED_FLAG(excess), .TOUCH_FLAG(flag), .ALERT_N(alert_n));
	tecc_cal_model i_tecc_cal_model (.clk(clk), .rst(rst), .start(cal_start), .dly(dly),
		.res(res), .done(cal_done), .result(cal_result));
	// Clock, start counting and hang guard
	initial forever #12.5 clk = ~clk;
	always @(negedge clk) begin
		cycles++;
		if (cal_start === 1'b1) starts++;
		if (cycles == 5000) begin
			err_total++;
			results();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic chk(input string what, input logic [29:0] seen, input logic [29:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		addr = a;
		rd = 1'b1;
		cyc(1);
		rd = 1'b0;
		chk($sformatf("reg %h", a), 30'(rdata), 30'(exp));
	endtask : rd_reg
	task automatic cal_wait;
		for (int i = 0; i < 100 && cal_done !== 1'b1; i++) cyc(1);
		cyc(2);
	endtask : cal_wait
	task automatic alert_in(input int n, output logic seen);
		seen = 1'b0;
		repeat (n) begin
			cyc(1);
			if (alert_n === 1'b0) seen = 1'b1;
		end
	endtask : alert_in
	task automatic clear;
		clr = 1'b1;
		cyc(1);
		clr = 1'b0;
		cyc(1);
	endtask : clear
	task automatic t_regs;
		rd_reg(ADDR_CAL_TRIGGER, RST_CAL_TRIGGER);
		rd_reg(ADDR_ALERT_ENABLE, RST_ALERT_ENABLE);
		rd_reg(ADDR_REPEAT_ENABLE, RST_REPEAT_ENABLE);
		rd_reg(ADDR_LIMIT_CONFIG, RST_LIMIT_CONFIG);
		rd_reg(8'h30, 8'h00);
		wr_reg(ADDR_LIMIT_CONFIG, 8'hFF);
		rd_reg(ADDR_LIMIT_CONFIG, 8'h8C);
		wr_reg(ADDR_LIMIT_CONFIG, RST_LIMIT_CONFIG);
		$display("test regs done");
	endtask : t_regs
	task automatic t_cal;
		int s0;
		act_en = 3'h7;
		repeat (3) cal_wait();
		rd_reg(ADDR_CAL_TRIGGER, 8'h00);
		chk("cal values", cal_val, {3{10'h123}});
		dly = 8'h14;
		s0 = starts;
		wr_reg(ADDR_CAL_TRIGGER, 8'h06);
		for (int i = 0; i < 50 && cal_start !== 1'b1; i++) cyc(1);
		chk("sel", 30'(cal_sel), 30'h1);
		wr_reg(ADDR_CAL_TRIGGER, 8'h00);
		cal_wait();
		cyc(6);
		chk("runs", 30'(starts - s0), 30'h1);
		rd_reg(ADDR_CAL_TRIGGER, 8'h00);
		dly = 8'h04;
		res = 10'h3FF;
		wr_reg(ADDR_CAL_TRIGGER, 8'h04);
		cal_wait();
		chk("value 3", 30'(cal_val[29:20]), 30'h3FF);
		chk("fail limit", 30'(fail), 30'h1);
		rd_reg(ADDR_CAL_TRIGGER, 8'h04);
		clear();
		res = 10'h200;
		noise = 3'h2;
		wr_reg(ADDR_CAL_TRIGGER, 8'h02);
		cal_wait();
		noise = 3'h0;
		chk("fail flag", 30'(fail), 30'h1);
		rd_reg(ADDR_CAL_TRIGGER, 8'h02);
		clear();
		chk("fail cleared", 30'(fail), 30'h0);
		res = 10'h123;
		s0 = starts;
		sleep = 1'b1;
		cyc(2);
		sleep = 1'b0;
		repeat (3) cal_wait();
		stby = 1'b1;
		cyc(2);
		stby_en = 3'h1;
		cal_wait();
		chk("wake runs", 30'(starts - s0), 30'h4);
		rd_reg(ADDR_CAL_TRIGGER, 8'h00);
		stby = 1'b0;
		repeat (2) cal_wait();
		chk("active runs", 30'(starts - s0), 30'h6);
		$display("test cal done");
	endtask : t_cal
	task automatic t_block;
		logic [2:0] exp [4] = '{3'h1, 3'h3, 3'h7, 3'h7};
		for (int n = 0; n < 4; n++) begin
			wr_reg(ADDR_LIMIT_CONFIG, {1'b1, 3'h0, 2'(n), 2'h0});
			raw = 3'h7;
			cyc(2);
			chk("flag", 30'(flag), 30'(exp[n]));
			chk("excess", 30'(excess), 30'(n < 2));
			raw = 3'h0;
			cyc(2);
		end
		wr_reg(ADDR_LIMIT_CONFIG, 8'h00);
		raw = 3'h7;
		cyc(2);
		chk("flag open", 30'({excess, flag}), 30'h7);
		wr_reg(ADDR_LIMIT_CONFIG, RST_LIMIT_CONFIG);
		raw = 3'h2;
		cyc(2);
		raw = 3'h3;
		cyc(2);
		chk("flag kept", 30'(flag), 30'h2);
		raw = 3'h5;
		cyc(2);
		chk("flag order", 30'(flag), 30'h1);
		raw = 3'h0;
		$display("test block done");
	endtask : t_block
	task automatic t_alert;
		logic s;
		logic s2;
		wr_reg(ADDR_REPEAT_ENABLE, 8'h00);
		wr_reg(ADDR_ALERT_ENABLE, 8'h01);
		cyc(6);
		clear();
		raw = 3'h2;
		alert_in(12, s);
		raw = 3'h0;
		alert_in(4, s2);
		chk("masked", 30'({s, s2}), 30'h0);
		raw = 3'h1;
		alert_in(4, s);
		chk("touch", 30'(s), 30'h1);
		cyc(10);
		chk("held low", 30'(alert_n), 30'h0);
		clear();
		alert_in(STEP * 8, s);
		chk("no repeat", 30'(s), 30'h0);
		raw = 3'h0;
		alert_in(4, s);
		chk("release", 30'(s), 30'h1);
		clear();
		wr_reg(ADDR_REPEAT_ENABLE, 8'h01);
		raw = 3'h1;
		alert_in(4, s);
		clear();
		alert_in(STEP * 6, s);
		chk("repeat", 30'(s), 30'h1);
		clear();
		alert_in(STEP * 3, s);
		chk("repeat again", 30'(s), 30'h1);
		rpt_iv = 4'h2;
		clear();
		for (int i = 0; i < 40 && alert_n !== 1'b0; i++) cyc(1);
		clear();
		alert_in(STEP + 2, s);
		chk("interval gap", 30'(s), 30'h0);
		alert_in(STEP * 2, s);
		chk("interval hit", 30'(s), 30'h1);
		raw = 3'h0;
		for (int k = 0; k < 2; k++) begin
			rel_dis = k[0];
			cyc(4);
			clear();
			raw = 3'h1;
			alert_in(4, s);
			chk("short touch", 30'(s), 30'h1);
			clear();
			raw = 3'h0;
			alert_in(6, s);
			chk("short release", 30'(s), 30'(k == 0));
		end
		$display("test alert done");
	endtask : t_alert
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results
	// Reset for five cycles, then run the scenarios
	initial begin
		cyc(5);
		rst = 1'b0;
		cyc(1);
		t_regs();
		t_cal();
		t_block();
		t_alert();
		results();
	end
endmodule : tecc_top_tb_top
